/* rtl/ccdr_sensor.sv */
// Digital model of a frame-transfer image sensor driven by external gate clocks.
// Assumes gate inputs are synchronous to I_MCLK; a gate pulse is its rising edge.
`timescale 1ns/10ps
`default_nettype none
`include "ccdr_defines.svh"

module ccdr_sensor #(
  parameter int LINES = `CCDR_LINES,
  parameter int COLS = `CCDR_COLS
) (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire ccdr_pkg::ccdr_gates_t I_GATES,
  input wire logic [`CCDR_DATA_W-1:0] I_LIGHT,
  output ccdr_pkg::ccdr_pixel_t O_PIXEL,
  output logic O_IMAGE_EMPTY
);

  localparam logic [`CCDR_CNT_W-1:0] LINES_ALL = `CCDR_CNT_W'(LINES + 1);
  localparam logic [`CCDR_CNT_W-1:0] FIRST_PIX = `CCDR_CNT_W'(`CCDR_DUMMY_CELLS);
  localparam logic [`CCDR_CNT_W-1:0] FIRST_ACT = `CCDR_CNT_W'(`CCDR_DUMMY_CELLS + `CCDR_DARK_COLS);
  localparam logic [`CCDR_CNT_W-1:0] EXTRA_COL = `CCDR_CNT_W'(`CCDR_DUMMY_CELLS + COLS);

  ccdr_pkg::ccdr_state_t s_q;
  ccdr_pkg::ccdr_state_t s_d;
  logic [`CCDR_DATA_W-1:0] rdata;
  logic img_edge;
  logic sto_edge;
  logic drain_edge;
  logic shift_edge;
  logic dump;
  logic xfer;
  logic line_load;
  logic mem_we;
  logic [`CCDR_DATA_W-1:0] wdata;
  logic [`CCDR_DATA_W:0] sum;

  // ---------------------------------------------------------------
  // Gate pulse decode
  // ---------------------------------------------------------------
  // Charge moves when both image gates become high together; an edge on one gate while the other is low moves no charge.
  assign img_edge = I_GATES.image_gate_one && I_GATES.image_gate_two &&
                    !(s_q.gates_prev.image_gate_one && s_q.gates_prev.image_gate_two);
  assign sto_edge = I_GATES.storage_gate && !s_q.gates_prev.storage_gate;
  assign drain_edge = I_GATES.overflow_drain_gate && !s_q.gates_prev.overflow_drain_gate;
  assign shift_edge = I_GATES.horizontal_shift_gate && !s_q.gates_prev.horizontal_shift_gate;
  assign dump = img_edge && !sto_edge;
  assign xfer = img_edge && sto_edge;
  assign line_load = sto_edge && !img_edge;
  // The extra line sits nearest the clear line, so it is the first row moved.
  assign wdata = (s_q.xfer_cnt == '0) ? `CCDR_BLACK : s_q.charge;
  assign mem_we = xfer;
  assign sum = {1'b0, s_q.charge} + {1'b0, I_LIGHT};

  ccdr_line_mem #(
    .WIDTH(`CCDR_DATA_W),
    .DEPTH(`CCDR_LINES_ALL),
    .AW(`CCDR_ADDR_W)
  ) u_store (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_we(mem_we),
    .i_waddr(s_q.wr_ptr),
    .i_wdata(wdata),
    .i_raddr(s_q.rd_ptr),
    .o_rdata(rdata)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.gates_prev = I_GATES;
    s_d.load_pend = 1'b0;
    s_d.pix.valid = 1'b0;
    s_d.pix.dark = 1'b0;
    s_d.pix.data = `CCDR_BLACK;

    // Integration. A drain pulse clips the well to the usable level; without
    // it the charge only stops at saturation and would bloom in a real part.
    if (sum[`CCDR_DATA_W]) begin
      s_d.charge = `CCDR_SAT_LEVEL;
    end else begin
      s_d.charge = sum[`CCDR_DATA_W-1:0];
    end
    if (drain_edge && s_d.charge > `CCDR_USE_LEVEL) begin
      s_d.charge = `CCDR_USE_LEVEL;
    end
    if (s_d.charge != `CCDR_BLACK) begin
      s_d.image_empty = 1'b0;
    end

    if (dump) begin
      // Dumped rows go out through the clear line, not into storage.
      // A cut transfer would leave the write pointer mid-store, so it restarts here
      // to keep row 0 of the next frame the dark extra line.
      s_d.xfer_cnt = '0;
      s_d.wr_ptr = '0;
      if (s_q.clr_cnt == `CCDR_CNT_W'(`CCDR_CLEAR_PULSES - 1)) begin
        s_d.clr_cnt = '0;
        s_d.charge = `CCDR_BLACK;
        s_d.image_empty = 1'b1;
      end else begin
        s_d.clr_cnt = s_q.clr_cnt + `CCDR_CNT_W'(1);
      end
    end else if (xfer) begin
      // Rows move whole; after the last row the image area holds nothing.
      s_d.clr_cnt = '0;
      s_d.wr_ptr = (s_q.wr_ptr == `CCDR_ADDR_W'(LINES)) ? '0 :
                   s_q.wr_ptr + `CCDR_ADDR_W'(1);
      if (s_q.xfer_cnt == LINES_ALL - `CCDR_CNT_W'(1)) begin
        s_d.xfer_cnt = '0;
        s_d.charge = `CCDR_BLACK;
        s_d.image_empty = 1'b1;
        s_d.rd_ptr = '0;
      end else begin
        s_d.xfer_cnt = s_q.xfer_cnt + `CCDR_CNT_W'(1);
      end
    end

    if (line_load) begin
      s_d.load_pend = 1'b1;
      s_d.rd_ptr = (s_q.rd_ptr == `CCDR_ADDR_W'(LINES)) ? '0 :
                   s_q.rd_ptr + `CCDR_ADDR_W'(1);
    end
    if (s_q.load_pend) begin
      s_d.line_level = rdata;
      s_d.pos = '0;
    end else if (shift_edge && s_q.pos <= EXTRA_COL) begin
      s_d.pos = s_q.pos + `CCDR_CNT_W'(1);
      if (s_q.pos >= FIRST_PIX) begin
        s_d.pix.valid = 1'b1;
        if (s_q.pos < FIRST_ACT || s_q.pos == EXTRA_COL) begin
          s_d.pix.dark = 1'b1;
        end else begin
          s_d.pix.data = s_q.line_level;
        end
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign O_PIXEL = s_q.pix;
  assign O_IMAGE_EMPTY = s_q.image_empty;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  row_bound_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    xfer |=> s_q.wr_ptr <= `CCDR_ADDR_W'(LINES))
    else $error("storage row pointer past the last row");

  dark_cols_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (shift_edge && !s_q.load_pend && s_q.pos >= FIRST_PIX && s_q.pos < FIRST_ACT)
    |=> O_PIXEL.valid && O_PIXEL.dark && O_PIXEL.data == `CCDR_BLACK)
    else $error("shielded column did not read black");

  extra_line_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (xfer && s_q.xfer_cnt == '0) |-> wdata == `CCDR_BLACK)
    else $error("first transferred row was not the dark extra line");

  active_span_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (O_PIXEL.valid && !O_PIXEL.dark) |->
    ($past(s_q.pos) >= FIRST_ACT && $past(s_q.pos) < FIRST_ACT + `CCDR_CNT_W'(`CCDR_ACTIVE_COLS)))
    else $error("active pixel outside the 324 active columns");

  clear_path_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    dump |-> !mem_we ##1 $stable(s_q.wr_ptr))
    else $error("cleared charge reached the storage area");

  node_reset_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (O_PIXEL.valid ##1 !O_PIXEL.valid) |-> O_PIXEL.data == `CCDR_BLACK)
    else $error("detection node not back at reference after a pixel");

  dummy_cells_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (shift_edge && !s_q.load_pend && s_q.pos < FIRST_PIX) |=> !O_PIXEL.valid)
    else $error("pixel emitted from a dummy cell");

  line_start_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    s_q.load_pend |=> s_q.pos == '0 && !O_PIXEL.valid)
    else $error("landed line did not restart at the first dummy cell");

  clear_done_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (dump && s_q.clr_cnt == `CCDR_CNT_W'(`CCDR_CLEAR_PULSES - 1)) |=> O_IMAGE_EMPTY)
    else $error("image area not empty after a full clear");

  extra_col_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (shift_edge && !s_q.load_pend && s_q.pos == EXTRA_COL) |=>
    O_PIXEL.valid && O_PIXEL.dark && O_PIXEL.data == `CCDR_BLACK)
    else $error("extra right column did not read black");

  line_end_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (shift_edge && !s_q.load_pend && s_q.pos > EXTRA_COL) |=> !O_PIXEL.valid)
    else $error("pixel emitted past the end of a line");

  frame_end_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (xfer && s_q.xfer_cnt == LINES_ALL - `CCDR_CNT_W'(1)) |=>
    O_IMAGE_EMPTY && s_q.wr_ptr == '0 && s_q.rd_ptr == '0)
    else $error("frame transfer did not end on the last storage row");

endmodule

`default_nettype wire

/* rtl/ccdr_defines.svh */
// Constants for the frame-transfer sensor readout model.
// Included by the package and by every design file; definitions only.
`ifndef CCDR_DEFINES_SVH
`define CCDR_DEFINES_SVH

`define CCDR_DATA_W 16
`define CCDR_ADDR_W 8
`define CCDR_CNT_W 9
`define CCDR_LINES 243
`define CCDR_LINES_ALL 244
`define CCDR_COLS 336
`define CCDR_DARK_COLS 12
`define CCDR_ACTIVE_COLS 324
`define CCDR_DUMMY_CELLS 2
`define CCDR_CLEAR_PULSES 244
`define CCDR_SAT_LEVEL 16'hFFFF
`define CCDR_USE_LEVEL 16'h5555
`define CCDR_BLACK 16'h0000

`endif

/* rtl/ccdr_pkg.sv */
// Types shared by the sensor readout model.
// Assumes ccdr_defines.svh is on the include path.
`include "ccdr_defines.svh"

package ccdr_pkg;

  typedef struct packed {
    logic overflow_drain_gate;
    logic image_gate_one;
    logic image_gate_two;
    logic storage_gate;
    logic horizontal_shift_gate;
  } ccdr_gates_t;

  typedef struct packed {
    logic valid;
    logic dark;
    logic [`CCDR_DATA_W-1:0] data;
  } ccdr_pixel_t;

  typedef struct packed {
    ccdr_gates_t gates_prev;
    logic [`CCDR_DATA_W-1:0] charge;
    logic [`CCDR_CNT_W-1:0] clr_cnt;
    logic [`CCDR_CNT_W-1:0] xfer_cnt;
    logic [`CCDR_ADDR_W-1:0] wr_ptr;
    logic [`CCDR_ADDR_W-1:0] rd_ptr;
    logic load_pend;
    logic [`CCDR_DATA_W-1:0] line_level;
    logic [`CCDR_CNT_W-1:0] pos;
    logic image_empty;
    ccdr_pixel_t pix;
  } ccdr_state_t;

endpackage

/* rtl/ccdr_line_mem.sv */
// Storage-area memory: one word per stored line, registered read data.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
`include "ccdr_defines.svh"

module ccdr_line_mem #(
  parameter int WIDTH = `CCDR_DATA_W,
  parameter int DEPTH = `CCDR_LINES_ALL,
  parameter int AW = `CCDR_ADDR_W
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem_q[i_raddr];
    end
  end

endmodule

`default_nettype wire

/* dv/ccdr_ctrl_model.sv */
// Behavioural timing generator that drives the sensor's five gate inputs.
// Assumes a free-running clock; every gate change lands 1 ns after a rising edge.
`timescale 1ns/10ps
`default_nettype none

module ccdr_ctrl_model (
  input wire logic i_clk,
  output var ccdr_pkg::ccdr_gates_t o_gates
);
  // ----------------------------------------------------------------
  // Gate pulses
  // ----------------------------------------------------------------
  // One cycle high then one low: the fastest spacing the sensor takes.
  initial o_gates = '0;

  task automatic pulse(input logic [4:0] g);
    @(posedge i_clk);
    #1 o_gates = ccdr_pkg::ccdr_gates_t'(g);
    @(posedge i_clk);
    #1 o_gates = '0;
  endtask

  task automatic clear_area();
    repeat (244) pulse(5'h0C);
  endtask

  task automatic drain_burst(input int n);
    repeat (n) pulse(5'h10);
  endtask

  task automatic frame_xfer();
    repeat (244) pulse(5'h0E);
  endtask

  // Interlace displaces the sensing positions with one image gate alone; no charge moves.
  task automatic field_shift();
    pulse(5'h08);
  endtask

  // A serial edge in the cycle the line lands is lost, so one idle cycle is added.
  // With correlated double sampling each serial pulse gets a third, reference phase.
  task automatic read_line(input int extra, input bit cds);
    pulse(5'h02);
    @(posedge i_clk);
    repeat (339 + extra) begin
      pulse(5'h01);
      if (cds) begin
        @(posedge i_clk);
      end
    end
  endtask
endmodule

`default_nettype wire

/* dv/ccdr_sensor_tb.sv */
// Self-checking bench for the sensor model: clear, expose, transfer, read lines.
// Assumes ccdr_pkg is compiled first and ccdr_defines.svh is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "ccdr_defines.svh"

module ccdr_sensor_tb;
  logic mclk;
  logic rst_n;
  ccdr_pkg::ccdr_gates_t gates;
  logic [15:0] light;
  ccdr_pkg::ccdr_pixel_t pixel;
  logic image_empty;
  ccdr_pkg::ccdr_pixel_t exp_q[$];
  int miscompares;
  int checks;
  integer seed;
  logic [15:0] lvl;
  logic [15:0] lvl_exp;
  int expo;

  ccdr_sensor u_dut (.I_MCLK(mclk), .I_RST_N(rst_n), .I_GATES(gates), .I_LIGHT(light),
    .O_PIXEL(pixel), .O_IMAGE_EMPTY(image_empty));
  ccdr_ctrl_model u_ctrl (.i_clk(mclk), .o_gates(gates));

  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic cmp_pix(input ccdr_pkg::ccdr_pixel_t e, input ccdr_pkg::ccdr_pixel_t g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch pixel expected %h seen %h", e, g);
    end
  endtask

  task automatic cmp_flag(input logic e, input logic g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch flag expected %h seen %h", e, g);
    end
  endtask

  task automatic close_out();
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Between pixels the output must read all zero, so idle cycles are checked too.
  // Sampled mid-cycle, where the registered pixel has settled.
  always @(negedge mclk) begin
    if (rst_n === 1'h1) begin
      if (pixel.valid !== 1'h1) begin
        cmp_pix('0, pixel);
      end else if (exp_q.size() == 0) begin
        cmp_pix('0, pixel);
      end else begin
        cmp_pix(exp_q.pop_front(), pixel);
      end
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  task automatic expect_line(input logic [15:0] v);
    for (int c = 0; c < `CCDR_DARK_COLS + `CCDR_ACTIVE_COLS + 1; c++) begin
      if (c < `CCDR_DARK_COLS || c >= `CCDR_DARK_COLS + `CCDR_ACTIVE_COLS) begin
        exp_q.push_back({1'h1, 1'h1, 16'h0000});
      end else begin
        exp_q.push_back({1'h1, 1'h0, v});
      end
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask

  initial begin
    #1000000;
    miscompares++;
    close_out();
  end

  initial begin
    seed = 32'h0BE5;
    rst_n = 1'h0;
    light = 16'h0000;
    miscompares = 0;
    checks = 0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'h1;
    u_ctrl.clear_area();
    settle();
    cmp_flag(1'h1, image_empty);
    for (int f = 0; f < 3; f++) begin
      lvl = (f == 2) ? 16'h4000 : 16'h0001 + (16'($random(seed)) & 16'h03FF);
      expo = 4 + ($random(seed) & 7);
      @(posedge mclk);
      #1 light = lvl;
      repeat (expo) @(posedge mclk);
      #1 light = 16'h0000;
      if (f != 1) begin
        u_ctrl.field_shift();
      end
      settle();
      cmp_flag(1'h0, image_empty);
      lvl_exp = (f == 0) ? 16'(lvl * expo) : (f == 1) ? 16'h0000 : `CCDR_USE_LEVEL;
      if (f == 1) begin
        u_ctrl.clear_area();
        settle();
        cmp_flag(1'h1, image_empty);
      end
      u_ctrl.drain_burst(3);
      u_ctrl.frame_xfer();
      settle();
      cmp_flag(1'h1, image_empty);
      expect_line(16'h0000);
      u_ctrl.read_line(0, 1'b0);
      for (int l = 1; l < 3; l++) begin
        expect_line(lvl_exp);
        u_ctrl.read_line((l == 2) ? 2 : 0, f == 2);
      end
    end
    settle();
    cmp_flag(1'h1, exp_q.size() == 0);
    close_out();
  end
endmodule

`default_nettype wire
